// ==== src/stop_wake_consts.svh ====
// constants for the stop-mode wake and clock guard block
`ifndef STOP_WAKE_CONSTS_SVH
`define STOP_WAKE_CONSTS_SVH
// ----------------------------------------------------------------
// register addresses
// ----------------------------------------------------------------
`define UNLOCK_KEY_ADDR 8'hc7
`define STANDBY_CTRL_ADDR 8'hc4
`define WATCHDOG_CTRL_ADDR 8'hd8
`define PROG_SIZE_ADDR 8'hc2
`define POWER_CTRL_ADDR 8'h87
// ----------------------------------------------------------------
// key values and field positions
// ----------------------------------------------------------------
`define UNLOCK_FIRST 8'haa
`define UNLOCK_SECOND 8'h55
`define STBY_REF_BIT 0
`define RING_SEL_BIT 1
`define RING_USE_BIT 2
`define STOP_BIT 1
`define WD_PROT_MASK 8'h4b
`define PROG_PROT_MASK 8'h07
`define STBY_PROT_MASK 8'h01
// ----------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------
`define STANDBY_RESET 8'h00
`define WATCHDOG_RESET 8'h00
`define PROG_SIZE_RESET 8'h05
`define WINDOW_CYCLES 4'h3
`define XTAL_HANDOVER_COUNT 17'h10000
`endif

// ==== src/stop_wake_pkg.sv ====
// types for the stop-mode wake and clock guard block
package stop_wake_pkg;
  // one special-function register write strobe with its data
  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] data;
  } sfr_write_t;
  // source of the system clock
  typedef enum logic [2:0] {
    CLK_XTAL = 3'h1,
    CLK_STOP = 3'h2,
    CLK_RING = 3'h4
  } clk_state_t;
endpackage : stop_wake_pkg

// ==== src/sync3.sv ====
// three-stage input synchroniser with agreement on the last two
`timescale 1ns/1ps
`include "stop_wake_consts.svh"
`default_nettype none
module sync3 (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic d_i,
  output logic q_o
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  // ----------------------------------------------------------------
  // shift chain; s1 feeds only s2
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      q_o <= 1'b0;
    end else begin
      s1_q <= d_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      // change counts only when stages two and three agree
      if (s2_q == s3_q) begin
        q_o <= s3_q;
      end
    end
  end
endmodule : sync3
`default_nettype wire

// ==== src/xtal_counter.sv ====
// counts crystal cycles until the ring hands over to the crystal
`timescale 1ns/1ps
`include "stop_wake_consts.svh"
`default_nettype none
module xtal_counter (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic run_i,
  output logic done_o
);
  logic [16:0] cnt_q; // crystal clocks since ring start
  // ----------------------------------------------------------------
  // counter: restarts on start, raises done at the handover count
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i || !(start_i || run_i)) begin
      cnt_q <= 17'h00000;
      done_o <= 1'b0;
    end else if (start_i) begin
      // the start edge is already the first crystal clock of the period
      cnt_q <= 17'h00001;
      done_o <= 1'b0;
    end else if (cnt_q != `XTAL_HANDOVER_COUNT) begin
      cnt_q <= cnt_q + 17'h00001;
      done_o <= (cnt_q == `XTAL_HANDOVER_COUNT - 17'h00001);
    end
  end
endmodule : xtal_counter
`default_nettype wire

// ==== src/stop_wake_clock_guard.sv ====
// stop-mode reference, ring start-up and timed-access protection
// ----------------------------------------------------------------
// How it works
// - standby reference select resets to zero
// - select set keeps band-gap on in stop
// - power-fail events then wake from stop
// - select ignored outside stop mode
// - stop halts crystal and all clocks
// - ring select: interrupt wake runs on ring
// - crystal takes over after 65536 clocks
// - default wake waits for the crystal; the code returns to CLK_XTAL at once, with no wait
// - ring-in-use flag shows ring clock
// - key aa then 55 opens three cycles
// - protected writes ignored without fresh unlock
// - protected bits in watchdog, standby, size
// - power control bit one enters stop
// - only external interrupt, power-fail (select set) or reset wakes
// ----------------------------------------------------------------
`timescale 1ns/1ps
`include "stop_wake_consts.svh"
`default_nettype none
module stop_wake_clock_guard (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire stop_wake_pkg::sfr_write_t sfr_wr_i,
  input wire logic ext_int_n_i,
  input wire logic power_fail_i,
  output logic [7:0] standby_clock_control_o,
  output logic [7:0] watchdog_control_o,
  output logic [7:0] program_memory_size_o,
  output logic bandgap_on_o,
  output logic xtal_run_o,
  output logic clocks_on_o,
  output logic ring_run_o,
  output logic power_fail_wake_o
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic key_first_q;      // aa has been written
  logic [3:0] win_q;      // cycles left in the open window
  logic stby_ref_q;       // standby reference select
  logic ring_sel_q;       // ring start select
  logic [7:0] wd_q;       // watchdog control
  logic [7:0] size_q;     // program memory size
  stop_wake_pkg::clk_state_t state_q;
  logic ext_int_s;        // synchronised external interrupt, active high
  logic pf_s;             // synchronised power-fail detect
  logic ring_start;       // pulse: ring period begins
  logic handover;         // crystal count reached
  logic key_wr;
  logic open_win;
  logic prot_wr;
  logic in_stop;
  logic wake;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  sync3 int_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(~ext_int_n_i),
    .q_o(ext_int_s)
  );
  sync3 pf_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(power_fail_i),
    .q_o(pf_s)
  );

  // ----------------------------------------------------------------
  // timed access unlock
  // ----------------------------------------------------------------
  assign key_wr = sfr_wr_i.wr && (sfr_wr_i.addr == `UNLOCK_KEY_ADDR);
  assign open_win = win_q != 4'h0;
  // a protected write is a write to a register holding guarded bits while the window is open
  assign prot_wr = sfr_wr_i.wr && open_win &&
                   (sfr_wr_i.addr == `WATCHDOG_CTRL_ADDR ||
                    sfr_wr_i.addr == `STANDBY_CTRL_ADDR ||
                    sfr_wr_i.addr == `PROG_SIZE_ADDR);

  // key sequence tracker; any other key value restarts it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      key_first_q <= 1'b0;
    end else if (key_wr) begin
      key_first_q <= (sfr_wr_i.data == `UNLOCK_FIRST);
    end
  end

  // window counter: opens on 55 after aa, closes on use or timeout
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      win_q <= 4'h0;
    end else if (key_wr && key_first_q &&
                 sfr_wr_i.data == `UNLOCK_SECOND) begin
      win_q <= `WINDOW_CYCLES;
    end else if (key_wr || prot_wr) begin
      win_q <= 4'h0;
    end else if (open_win) begin
      win_q <= win_q - 4'h1;
    end
  end

  // ----------------------------------------------------------------
  // standby control: bit 0 guarded, bit 1 free, bit 2 read-only
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stby_ref_q <= 1'(`STANDBY_RESET >> `STBY_REF_BIT);
      ring_sel_q <= 1'b0;
    end else if (sfr_wr_i.wr && sfr_wr_i.addr == `STANDBY_CTRL_ADDR) begin
      ring_sel_q <= sfr_wr_i.data[`RING_SEL_BIT];
      if (open_win) begin
        stby_ref_q <= sfr_wr_i.data[`STBY_REF_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // watchdog control and memory size: guarded bits need the window
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wd_q <= `WATCHDOG_RESET;
    end else if (sfr_wr_i.wr && sfr_wr_i.addr == `WATCHDOG_CTRL_ADDR) begin
      if (open_win) begin
        wd_q <= sfr_wr_i.data;
      end else begin
        wd_q <= (wd_q & `WD_PROT_MASK) |
                (sfr_wr_i.data & ~`WD_PROT_MASK);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      size_q <= `PROG_SIZE_RESET;
    end else if (sfr_wr_i.wr && sfr_wr_i.addr == `PROG_SIZE_ADDR) begin
      if (open_win) begin
        size_q <= sfr_wr_i.data & `PROG_PROT_MASK;
      end
    end
  end

  // ----------------------------------------------------------------
  // clock source state machine
  // ----------------------------------------------------------------
  assign in_stop = state_q == stop_wake_pkg::CLK_STOP;
  // internal interrupts have no clock in stop, so only pins wake
  assign wake = ext_int_s || (stby_ref_q && pf_s);
  assign ring_start = in_stop && ext_int_s && ring_sel_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= stop_wake_pkg::CLK_XTAL;
    end else begin
      case (state_q)
        stop_wake_pkg::CLK_XTAL: begin
          if (sfr_wr_i.wr && sfr_wr_i.addr == `POWER_CTRL_ADDR &&
              sfr_wr_i.data[`STOP_BIT]) begin
            state_q <= stop_wake_pkg::CLK_STOP;
          end
        end
        stop_wake_pkg::CLK_STOP: begin
          if (ring_start) begin
            state_q <= stop_wake_pkg::CLK_RING;
          end else if (wake) begin
            state_q <= stop_wake_pkg::CLK_XTAL;
          end
        end
        stop_wake_pkg::CLK_RING: begin
          if (handover) begin
            state_q <= stop_wake_pkg::CLK_XTAL;
          end
        end
        default: state_q <= stop_wake_pkg::CLK_XTAL;
      endcase
    end
  end

  // crystal is restarting while the ring runs; count its clocks
  xtal_counter handover_cnt (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(ring_start),
    .run_i(state_q == stop_wake_pkg::CLK_RING),
    .done_o(handover)
  );

  // ----------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      standby_clock_control_o <= `STANDBY_RESET;
      watchdog_control_o <= `WATCHDOG_RESET;
      program_memory_size_o <= `PROG_SIZE_RESET;
      bandgap_on_o <= 1'b1;
      xtal_run_o <= 1'b1;
      clocks_on_o <= 1'b1;
      ring_run_o <= 1'b0;
      power_fail_wake_o <= 1'b0;
    end else begin
      standby_clock_control_o <= {5'h00,
        state_q == stop_wake_pkg::CLK_RING, ring_sel_q, stby_ref_q};
      watchdog_control_o <= wd_q;
      program_memory_size_o <= size_q;
      // reference only gated in stop; other modes keep it on
      bandgap_on_o <= !in_stop || stby_ref_q;
      xtal_run_o <= !in_stop;
      clocks_on_o <= !in_stop;
      ring_run_o <= state_q == stop_wake_pkg::CLK_RING;
      power_fail_wake_o <= in_stop && stby_ref_q && pf_s;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  // ----------------------------------------------------------------
  // check helper: cycles spent on the ring, read only by the checks
  // ----------------------------------------------------------------
  logic [16:0] ring_len_q; // ring cycles so far, saturating
  // a counter keeps the handover check short; a long repetition
  // would make the property unrolling crawl
  always_ff @(posedge clk_i) begin
    if (rst_i || state_q != stop_wake_pkg::CLK_RING) begin
      ring_len_q <= 17'h00000;
    end else if (ring_len_q != `XTAL_HANDOVER_COUNT) begin
      ring_len_q <= ring_len_q + 17'h00001;
    end
  end

  sequence unlock_seq;
    key_wr && sfr_wr_i.data == `UNLOCK_FIRST ##1
    key_wr && sfr_wr_i.data == `UNLOCK_SECOND;
  endsequence

  unlock_opens_a: assert property (@(posedge clk_i)
    disable iff (rst_i) unlock_seq |=> win_q == 4'h3)
    else $error("window did not open");
  window_closes_a: assert property (@(posedge clk_i)
    disable iff (rst_i) unlock_seq ##1 !sfr_wr_i.wr [*3] |=> !open_win)
    else $error("window stayed open");
  locked_bgs_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !open_win |=> stby_ref_q == $past(stby_ref_q))
    else $error("protected bit changed while locked");
  // the other guarded registers hold their guarded bits while locked
  size_locked_a: assert property (@(posedge clk_i)
    disable iff (rst_i) !open_win |=> size_q == $past(size_q))
    else $error("size changed while locked");
  wd_locked_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !open_win |=>
    (wd_q & `WD_PROT_MASK) == ($past(wd_q) & `WD_PROT_MASK))
    else $error("guarded watchdog bit changed while locked");
  one_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
    prot_wr |=> !open_win)
    else $error("window open after a protected write");
  bad_key_a: assert property (@(posedge clk_i) disable iff (rst_i)
    key_wr && sfr_wr_i.data != `UNLOCK_FIRST &&
    sfr_wr_i.data != `UNLOCK_SECOND |=> !key_first_q && !open_win)
    else $error("bad key left the sequence armed");
  reset_bgs_a: assert property (@(posedge clk_i)
    $fell(rst_i) |-> !stby_ref_q)
    else $error("reference select not clear after reset");
  stop_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
    in_stop |=> !clocks_on_o && !xtal_run_o)
    else $error("clocks on in stop");
  bandgap_stop_a: assert property (@(posedge clk_i)
    disable iff (rst_i) in_stop && stby_ref_q |=> bandgap_on_o)
    else $error("band-gap off with select set");
  bg_default_a: assert property (@(posedge clk_i) disable iff (rst_i)
    in_stop && !stby_ref_q |=> !bandgap_on_o)
    else $error("band-gap on in stop with select clear");
  bandgap_run_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !in_stop |=> bandgap_on_o)
    else $error("band-gap off outside stop");
  ring_wake_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ring_start |=> ##1 ring_run_o && standby_clock_control_o[2])
    else $error("ring not used after wake");
  plain_wake_a: assert property (@(posedge clk_i) disable iff (rst_i)
    in_stop && wake && !ring_sel_q |=> state_q == stop_wake_pkg::CLK_XTAL)
    else $error("plain wake did not return to crystal");
  no_wake_a: assert property (@(posedge clk_i) disable iff (rst_i)
    in_stop && !ext_int_s && !(stby_ref_q && pf_s) |=> in_stop)
    else $error("left stop without a wake source");
  // stop command: bit one of power control while on the crystal
  sequence stop_cmd_seq;
    state_q == stop_wake_pkg::CLK_XTAL && sfr_wr_i.wr &&
    sfr_wr_i.addr == `POWER_CTRL_ADDR && sfr_wr_i.data[`STOP_BIT];
  endsequence

  stop_entry_a: assert property (@(posedge clk_i) disable iff (rst_i)
    stop_cmd_seq |=> in_stop)
    else $error("stop not entered");
  stop_clocks_a: assert property (@(posedge clk_i) disable iff (rst_i)
    stop_cmd_seq |=> ##1 !xtal_run_o && !clocks_on_o)
    else $error("clocks still on after stop command");
  handover_a: assert property (@(posedge clk_i) disable iff (rst_i)
    handover |=> state_q == stop_wake_pkg::CLK_XTAL)
    else $error("no handover to crystal");
  pf_wake_a: assert property (@(posedge clk_i) disable iff (rst_i)
    in_stop && stby_ref_q && pf_s |=> power_fail_wake_o && !in_stop)
    else $error("power-fail did not wake from stop");
  ring_stay_a: assert property (@(posedge clk_i) disable iff (rst_i)
    state_q == stop_wake_pkg::CLK_RING &&
    ring_len_q < `XTAL_HANDOVER_COUNT - 17'h00001 |=>
    state_q == stop_wake_pkg::CLK_RING)
    else $error("ring left before the handover count");
  ring_leave_a: assert property (@(posedge clk_i) disable iff (rst_i)
    state_q == stop_wake_pkg::CLK_RING &&
    ring_len_q == `XTAL_HANDOVER_COUNT - 17'h00001 |=>
    state_q == stop_wake_pkg::CLK_XTAL)
    else $error("ring kept past the handover count");
endmodule : stop_wake_clock_guard
`default_nettype wire

// ==== verification/tb_top.sv ====
// self-checking bench for the stop-mode wake and clock guard block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // ------------------------------------------------------------
  // stimulus and observed signals
  // ------------------------------------------------------------
  logic clk_i = 1'b0; // 40 MHz system clock
  logic rst_i = 1'b1; // synchronous reset, held high at start
  stop_wake_pkg::sfr_write_t sfr_wr_i = '0; // register write strobe
  logic ext_int_n_i = 1'b1; // external interrupt pin, idle high
  logic power_fail_i = 1'b0; // power-fail detect, idle low
  logic [7:0] stby, wdog, psize; // register views
  logic bg_on, xtal_on, clk_on, ring_on, pf_wake; // status views
  int miscompares = 0; // mismatches seen
  int samples_checked = 0; // comparisons made
  int ring_cycles = 0; // cycles the ring flag stayed high
  always #12.5 clk_i = ~clk_i;
  stop_wake_clock_guard u_dut (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .sfr_wr_i(sfr_wr_i),
    .ext_int_n_i(ext_int_n_i),
    .power_fail_i(power_fail_i),
    .standby_clock_control_o(stby),
    .watchdog_control_o(wdog),
    .program_memory_size_o(psize),
    .bandgap_on_o(bg_on),
    .xtal_run_o(xtal_on),
    .clocks_on_o(clk_on),
    .ring_run_o(ring_on),
    .power_fail_wake_o(pf_wake)
  );
  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  // closing report, the single exit of the run
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : give_verdict
  // compare one seen value against its expectation
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // one register write, held over exactly one rising edge
  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    @(negedge clk_i);
    sfr_wr_i = '{wr: 1'b1, addr: addr, data: data};
    @(negedge clk_i);
    sfr_wr_i = '0;
  endtask : wr
  // key pair that opens the protected-write window
  // back to back, as two consecutive instructions would write them
  task automatic unlock;
    @(negedge clk_i);
    sfr_wr_i = '{wr: 1'b1, addr: 8'hc7, data: 8'haa};
    @(negedge clk_i);
    sfr_wr_i = '{wr: 1'b1, addr: 8'hc7, data: 8'h55};
    @(negedge clk_i);
    sfr_wr_i = '0;
  endtask : unlock
  // idle cycles so a write reaches the outputs
  task automatic idle(input int n);
    repeat (n) @(negedge clk_i);
  endtask : idle
  // select a status output by index for bounded waits
  function automatic logic sig(input int sel);
    case (sel)
      0: return clk_on;
      1: return ring_on;
      default: return pf_wake;
    endcase
  endfunction : sig
  // bounded wait; running out counts a mismatch and ends the run
  task automatic waitv(input int sel, input logic val, input int lim);
    int n;
    n = 0;
    while (sig(sel) !== val) begin
      @(negedge clk_i);
      n++;
      if (n > lim) begin
        miscompares++;
        $display("[ERR] %0t wait on status %0d timed out", $time, sel);
        give_verdict();
      end
    end
  endtask : waitv
  // enter stop through the power control register
  task automatic enter_stop;
    wr(8'h87, 8'h02);
    waitv(0, 1'b0, 10);
    chk(xtal_on, 1'b0);
  endtask : enter_stop
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (8) @(negedge clk_i);
    rst_i = 1'b0;
    // reset values and reference outside stop
    chk(stby, 8'h00);
    chk(wdog, 8'h00);
    chk(psize, 8'h05);
    chk({bg_on, xtal_on, clk_on, ring_on}, 4'he);
    $display("test reset done");
    // protected writes without the key pair are dropped
    wr(8'hc4, 8'h01);
    wr(8'hc2, 8'h02);
    wr(8'hd8, 8'h4b);
    idle(2);
    chk(stby, 8'h00);
    chk(psize, 8'h05);
    chk(wdog & 8'h4b, 8'h00);
    // broken key order clears the sequence
    wr(8'hc7, 8'haa);
    wr(8'hc7, 8'h00);
    wr(8'hc7, 8'h55);
    wr(8'hc2, 8'h06);
    // window runs out after three cycles
    unlock();
    idle(2);
    wr(8'hc2, 8'h06);
    idle(2);
    chk(psize, 8'h05);
    $display("test refuse done");
    // default stop: reference off, power-fail cannot wake
    enter_stop();
    chk(bg_on, 1'b0);
    power_fail_i = 1'b1;
    idle(10);
    chk({clk_on, pf_wake}, 2'b00);
    power_fail_i = 1'b0;
    ext_int_n_i = 1'b0;
    waitv(0, 1'b1, 20);
    chk({xtal_on, ring_on}, 2'b10);
    ext_int_n_i = 1'b1;
    idle(4);
    $display("test plain stop done");
    // unlocked writes, one protected write per window
    unlock();
    idle(1);
    wr(8'hc2, 8'h03);
    wr(8'hc2, 8'h04);
    unlock();
    wr(8'hd8, 8'h4b);
    unlock();
    wr(8'hc4, 8'h01);
    idle(2);
    chk(psize, 8'h03);
    chk(wdog & 8'h4b, 8'h4b);
    chk(stby, 8'h01);
    // ring select is open; the reference bit stays protected
    wr(8'hc4, 8'h02);
    idle(2);
    chk(stby, 8'h03);
    $display("test unlock done");
    // reference kept in stop, power-fail wakes
    enter_stop();
    chk(bg_on, 1'b1);
    power_fail_i = 1'b1;
    waitv(2, 1'b1, 20);
    waitv(0, 1'b1, 20);
    power_fail_i = 1'b0;
    chk(clk_on, 1'b1);
    idle(4);
    $display("test power fail wake done");
    // interrupt wake on the ring, then crystal handover
    enter_stop();
    ext_int_n_i = 1'b0;
    waitv(1, 1'b1, 20);
    ext_int_n_i = 1'b1;
    chk(clk_on, 1'b1);
    chk(stby[2], 1'b1);
    // the ring must hold for exactly the handover count of clocks
    ring_cycles = 0;
    while (ring_on === 1'b1 && ring_cycles < 66000) begin
      @(negedge clk_i);
      ring_cycles++;
    end
    chk({7'h00, ring_cycles == 65536}, 8'h01);
    waitv(1, 1'b0, 10);
    chk(stby[2], 1'b0);
    chk(xtal_on, 1'b1);
    $display("test ring handover done");
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
